// [ncopm_core.sv]
// Numeric oscillator with phase modulator, parallel write port and sine output
//
// Operation
// - Frequency word 0 steps when choice low
// - Frequency word 1 steps when choice high
// - Two phase choices pick one of four offsets
// - Codes 0-3 freq halves, 4-7 offsets
// - Offset write keeps data bits 11..0
// - Frequency half write keeps all sixteen bits
// - 32-bit accumulator adds step, wraps
// - Output frequency is word times clock over 2^32
// - Choice change never clears the accumulator
// - Offset added to accumulator top bits
// - One offset step is 1/4096 cycle
// - Top twelve adjusted bits address table
// - Table maps 12-bit phase to 10-bit code
// - Strobe rise latches, next clock commits
// - Select inputs sampled on clock edges
// - Six cycle latency to amplitude output
// - Clear input zeroes only the accumulator
`default_nettype none

module ncopm_core
    import ncopm_pkg::*;
(
    input wire logic clock,                 // Master clock, 25 MHz
    input wire logic srst,                  // Synchronous reset, active high
    input wire logic wr_strobe_n,           // Write strobe, active low, rise latches
    input wire logic [2:0] register_select, // Destination register code
    input wire logic [15:0] write_data_bus, // Write data
    input wire logic freq_word_choice,      // Frequency word select
    input wire logic phase_choice_lo,       // Phase select, low bit
    input wire logic phase_choice_hi,       // Phase select, high bit
    input wire logic accum_clear_n,         // Accumulator clear, active low
    output logic [9:0] amplitude_code       // Amplitude code to the converter
);

    // ----------------------------------------------------------------
    // Address decoding helpers
    // ----------------------------------------------------------------

    // True for the four phase offset codes
    function automatic logic is_phase_addr(input logic [2:0] a);
        return a[NCOPM_ADDR_PHASE_BIT];
    endfunction

    // Slot index of a phase offset code
    function automatic logic [1:0] phase_slot(input logic [2:0] a);
        return a[1:0];
    endfunction

    ncopm_state_t st_q;
    ncopm_state_t st_d;
    logic [31:0] step;
    logic [9:0] table_code;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    always_comb
    begin
        st_d = st_q;

        st_d.wr_n_q = wr_strobe_n;
        st_d.cap_valid_q = 1'b0;
        if (wr_strobe_n && !st_q.wr_n_q)
        begin
            st_d.cap_valid_q = 1'b1;
            st_d.cap_addr_q = register_select;
            st_d.cap_data_q = write_data_bus;
        end

        // Commit one edge after capture; selects and accumulator keep running
        // destination decode
        if (st_q.cap_valid_q)
        begin
            if (is_phase_addr(st_q.cap_addr_q))
            begin
                st_d.phase_q[phase_slot(st_q.cap_addr_q)] = st_q.cap_data_q[11:0];
            end
            else
            begin
                case (st_q.cap_addr_q)
                    NCOPM_ADDR_F0_LO: st_d.freq0_q[15:0] = st_q.cap_data_q;
                    NCOPM_ADDR_F0_HI: st_d.freq0_q[31:16] = st_q.cap_data_q;
                    NCOPM_ADDR_F1_LO: st_d.freq1_q[15:0] = st_q.cap_data_q;
                    NCOPM_ADDR_F1_HI: st_d.freq1_q[31:16] = st_q.cap_data_q;
                    default: st_d.freq0_q = st_q.freq0_q;
                endcase
            end
        end

        // Stage 1: sample the selects
        // clocked sampling
        st_d.fsel_q = freq_word_choice;
        st_d.psel_q = {phase_choice_hi, phase_choice_lo};

        // Stage 2: accumulate and pick the offset
        // wrapping add
        st_d.acc_q = st_q.acc_q + step;
        if (!accum_clear_n)
        begin
            st_d.acc_q = NCOPM_ACC_RST;
        end
        st_d.offset_q = st_q.phase_q[st_q.psel_q];

        // Stage 3: offset lands on the top bits, 1/4096 cycle per step
        // offset addition
        st_d.sum_q = st_q.acc_q + {st_q.offset_q, 20'h0_0000};

        // Stage 4: truncate to the table address
        // keep top bits
        st_d.lut_addr_q = st_q.sum_q[31:NCOPM_ACC_TOP_LSB];

        // Stage 6: output register after the table stage
        // final stage
        st_d.amp_q = table_code;

        // System reset; the clear input alone touches only the accumulator register
        if (srst)
        begin
            st_d.wr_n_q = 1'b1;
            st_d.cap_valid_q = 1'b0;
            st_d.cap_addr_q = 3'h0;
            st_d.cap_data_q = 16'h0000;
            st_d.freq0_q = NCOPM_FREQ_RST;
            st_d.freq1_q = NCOPM_FREQ_RST;
            for (int i = 0; i < NCOPM_NUM_PHASE; i++)
            begin
                st_d.phase_q[i] = NCOPM_PHASE_RST;
            end
            st_d.fsel_q = 1'b0;
            st_d.psel_q = 2'b00;
            st_d.acc_q = NCOPM_ACC_RST;
            st_d.offset_q = NCOPM_PHASE_RST;
            st_d.sum_q = NCOPM_ACC_RST;
            st_d.lut_addr_q = NCOPM_PHASE_RST;
            st_d.amp_q = NCOPM_MIDSCALE;
        end
    end

    // Step chosen from the sampled select, not the raw pin
    // step selection
    assign step = st_q.fsel_q ? st_q.freq1_q : st_q.freq0_q;

    // State register
    always_ff @(posedge clock)
    begin
        st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // Sine stage (stage 5)
    // ----------------------------------------------------------------

    ncopm_sine_table u_sine (
        .clock(clock),
        .srst(srst),
        .phase_addr(st_q.lut_addr_q),
        .amp_code(table_code)
    );

    assign amplitude_code = st_q.amp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    strobe_capture_a: assert property (
        (!srst && $rose(wr_strobe_n) && !$past(srst)) |=> st_q.cap_valid_q
            && st_q.cap_addr_q == $past(register_select)
            && st_q.cap_data_q == $past(write_data_bus))
        else $error("strobe rise not captured");

    freq_half_store_a: assert property (
        (st_q.cap_valid_q && st_q.cap_addr_q == NCOPM_ADDR_F0_HI)
            |=> st_q.freq0_q[31:16] == $past(st_q.cap_data_q))
        else $error("frequency high half not stored");

    other_half_kept_a: assert property (
        (st_q.cap_valid_q && st_q.cap_addr_q == NCOPM_ADDR_F1_LO)
            |=> st_q.freq1_q[31:16] == $past(st_q.freq1_q[31:16])
            && st_q.freq1_q[15:0] == $past(st_q.cap_data_q))
        else $error("frequency half write disturbed other half");

    phase_store_a: assert property (
        (st_q.cap_valid_q && st_q.cap_addr_q == 3'h7)
            |=> st_q.phase_q[3] == $past(st_q.cap_data_q[11:0]))
        else $error("phase offset 3 not stored");

    acc_step_a: assert property (
        (!srst && accum_clear_n) |=> st_q.acc_q == $past(st_q.acc_q)
            + ($past(st_q.fsel_q) ? $past(st_q.freq1_q) : $past(st_q.freq0_q)))
        else $error("accumulator did not add selected word");

    acc_clear_a: assert property (
        !accum_clear_n |=> st_q.acc_q == NCOPM_ACC_RST
            && ($past(st_q.cap_valid_q) || ($stable(st_q.phase_q)
            && $stable(st_q.freq0_q) && $stable(st_q.freq1_q))))
        else $error("clear input misbehaved");

    select_sample_a: assert property (
        !srst |=> st_q.fsel_q == $past(freq_word_choice)
            && st_q.psel_q[1] == $past(phase_choice_hi)
            && st_q.psel_q[0] == $past(phase_choice_lo))
        else $error("selects not sampled on the edge");

    offset_pick_a: assert property (
        ({phase_choice_hi, phase_choice_lo} == 2'b10) ##1 $stable(st_q.phase_q)
            |=> st_q.offset_q == $past(st_q.phase_q[2]))
        else $error("wrong phase offset selected");

    addr_path_a: assert property (
        (!srst && !$past(srst) && !$past(srst, 2)) |-> st_q.lut_addr_q
            == 12'($past(st_q.acc_q[31:20], 2) + $past(st_q.offset_q, 2)))
        else $error("sine address not top bits of adjusted phase");

    // address to output in two edges
    midscale_out_a: assert property (
        (st_q.lut_addr_q == 12'h000) |-> ##2 amplitude_code == NCOPM_MIDSCALE)
        else $error("phase zero did not give midscale");

    // Main scenarios
    fsel_switch_c: cover property ($changed(st_q.fsel_q) && st_q.freq0_q != st_q.freq1_q);
    write_commit_c: cover property (st_q.cap_valid_q ##1 st_q.cap_valid_q == 1'b0);
    phase3_used_c: cover property (st_q.psel_q == 2'b11 && st_q.offset_q != 12'h000);
    clear_run_c: cover property (!accum_clear_n ##1 accum_clear_n ##3 st_q.acc_q != 32'h0000_0000);

endmodule

`default_nettype wire

// [ncopm_core_tb.sv]
// Self-checking bench for the oscillator core with a stage-exact reference
`default_nettype none

module ncopm_core_tb
    import ncopm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic srst = 1'b1;
    logic freq_word_choice = 1'b0;
    logic phase_choice_lo = 1'b0;
    logic phase_choice_hi = 1'b0;
    logic accum_clear_n = 1'b1;
    logic wr_strobe_n;
    logic [2:0] register_select;
    logic [15:0] write_data_bus;
    logic [9:0] amplitude_code;
    logic rand_sel = 1'b0;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int mask = 2;
    logic [31:0] f0, f1, acc, sum;
    logic [3:0][11:0] ph;
    logic [11:0] off, sine_table;
    logic [9:0] tab, amp;
    logic fs, cv, wrp;
    logic [1:0] ps;
    logic [2:0] ca;
    logic [15:0] cd;

    always #20 clock = ~clock;

    ncopm_core dut_u (.clock(clock), .srst(srst), .wr_strobe_n(wr_strobe_n),
        .register_select(register_select), .write_data_bus(write_data_bus),
        .freq_word_choice(freq_word_choice), .phase_choice_lo(phase_choice_lo),
        .phase_choice_hi(phase_choice_hi), .accum_clear_n(accum_clear_n),
        .amplitude_code(amplitude_code));

    ncopm_host_model host_u (.clock(clock), .wr_strobe_n(wr_strobe_n),
        .register_select(register_select), .write_data_bus(write_data_bus));

    // Quarter-symmetric sine, rounded half up
    function automatic logic [9:0] sine_code(input logic [11:0] a);
        logic [9:0] k;
        int mag;
        k = a[10] ? ~a[9:0] : a[9:0];
        mag = $rtoi(511.0 * $sin(3.14159265358979 * (real'(k) + 0.5) / 2048.0) + 0.5);
        return a[11] ? 10'(512 - mag) : 10'(512 + mag);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Reference pipeline, updated back to front so each stage sees old values
    // ----------------------------------------------------------------
    always @(posedge clock)
    begin
        if (srst)
        begin
            {f0, f1, ph, acc, off, sum, sine_table, fs, ps, cv} = '0;
            tab = NCOPM_MIDSCALE;
            amp = NCOPM_MIDSCALE;
            mask = 2;
        end
        else
        begin
            amp = tab;
            tab = sine_code(sine_table);
            sine_table = sum[31:20];
            sum = acc + {off, 20'h0_0000};
            off = ph[ps];
            acc = accum_clear_n ? acc + (fs ? f1 : f0) : 32'h0000_0000;
            if (cv)
            begin
                case (ca)
                    3'h0: f0[15:0] = cd;
                    3'h1: f0[31:16] = cd;
                    3'h2: f1[15:0] = cd;
                    3'h3: f1[31:16] = cd;
                    default: ph[ca[1:0]] = cd[11:0];
                endcase
            end
            cv = wr_strobe_n & ~wrp;
            ca = register_select;
            cd = write_data_bus;
            fs = freq_word_choice;
            ps = {phase_choice_hi, phase_choice_lo};
        end
        wrp = wr_strobe_n;
    end

    // Random select levels, changed every edge when enabled
    always @(posedge clock)
    begin
        if (rand_sel)
        begin
            freq_word_choice <= 1'($urandom);
            phase_choice_lo <= 1'($urandom);
            phase_choice_hi <= 1'($urandom);
        end
    end

    // Output compared every cycle except in reset and the two cycles after it, with a cycle ceiling against hangs
    always @(negedge clock)
    begin
        cycles++;
        if (mask > 0)
            mask--;
        else
            check("amplitude_code", amplitude_code, amp);
        if (cycles > 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [18:0] corner [6];
        logic [15:0] sdat [3];
        logic [9:0] sexp [3];
        corner = '{19'h0_ffff, 19'h1_ffff, 19'h2_0001, 19'h3_8000, 19'h4_f800, 19'h7_0fff};
        sdat = '{16'h0400, 16'h0800, 16'h0c00};
        sexp = '{10'h3ff, 10'h200, 10'h001};
        void'($urandom(32'h1229_36b0));
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        check("amp_after_reset", amplitude_code, NCOPM_MIDSCALE);
        host_u.clear_all();
        rand_sel <= 1'b1;
        for (int n = 0; n < 48; n++)
            host_u.write_reg(3'(n), 16'($urandom), 1 + $urandom % 3);
        foreach (corner[i])
            host_u.write_reg(corner[i][18:16], corner[i][15:0], 1);
        repeat (40) @(posedge clock);
        rand_sel <= 1'b0;
        accum_clear_n <= 1'b0;
        // Nonzero steps prove that the clear beats the accumulation
        for (int i = 0; i < 4; i++)
            host_u.write_reg(3'(i), 16'(i + 1), 2);
        repeat (6) @(posedge clock);
        @(negedge clock);
        check("amp_in_clear", amplitude_code, sine_code(ph[ps]));
        @(posedge clock);
        // Let the accumulator run again before the mid-run reset
        accum_clear_n <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b1;
        freq_word_choice <= 1'b0;
        phase_choice_lo <= 1'b0;
        phase_choice_hi <= 1'b0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            host_u.write_reg(3'h4, sdat[i], 1);
            repeat (8) @(posedge clock);
            @(negedge clock);
            check("amp_offset", amplitude_code, sexp[i]);
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire

// [ncopm_host_model.sv]
// Host processor model that loads the core's registers over the parallel write port
`default_nettype none

module ncopm_host_model
    import ncopm_pkg::*;
(
    input wire logic clock,               // Master clock
    output logic wr_strobe_n,             // Write strobe, active low
    output logic [2:0] register_select,   // Destination code
    output logic [15:0] write_data_bus    // Write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero, strobe released
    initial
    begin
        wr_strobe_n = 1'b1;
        register_select = 3'h0;
        write_data_bus = 16'h0000;
    end

    task automatic write_reg(input logic [2:0] addr, input logic [15:0] data, input int low);
        @(posedge clock);
        wr_strobe_n <= 1'b0;
        register_select <= addr;
        write_data_bus <= data;
        repeat (low) @(posedge clock);
        wr_strobe_n <= 1'b1;
        @(posedge clock);
        // Captured now; flip the bus so a late sample would see wrong data
        register_select <= ~addr;
        write_data_bus <= ~data;
    endtask

    task automatic clear_all();
        for (int i = 0; i < 8; i++)
            write_reg(3'(i), 16'h0000, 1);
    endtask
endmodule

`default_nettype wire

// [ncopm_pkg.sv]
// Shared constants and state layouts for the numeric oscillator phase modulator core
`default_nettype none

package ncopm_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int NCOPM_ACC_W = 32;          // Phase accumulator width
    localparam int NCOPM_HALF_W = 16;         // One write covers half a frequency word
    localparam int NCOPM_PHASE_W = 12;        // Phase offset and sine address width
    localparam int NCOPM_CODE_W = 10;         // Amplitude code width
    localparam int NCOPM_MAG_W = 9;           // Quarter-wave magnitude width
    localparam int NCOPM_QTR_DEPTH = 1024;    // Entries of the quarter-wave table
    localparam int NCOPM_NUM_PHASE = 4;       // Number of phase offset registers
    localparam int NCOPM_LATENCY = 6;         // Select to output, clock cycles; a write takes 7 from its capture edge

    // ----------------------------------------------------------------
    // Register select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] NCOPM_ADDR_F0_LO = 3'h0;
    localparam logic [2:0] NCOPM_ADDR_F0_HI = 3'h1;
    localparam logic [2:0] NCOPM_ADDR_F1_LO = 3'h2;
    localparam logic [2:0] NCOPM_ADDR_F1_HI = 3'h3;
    localparam int NCOPM_ADDR_PHASE_BIT = 2;  // Set for codes 4 to 7 (phase offsets)

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int NCOPM_ACC_TOP_LSB = 20;    // Accumulator bits 31..20 meet the offset
    localparam logic [31:0] NCOPM_FREQ_RST = 32'h0000_0000;
    localparam logic [11:0] NCOPM_PHASE_RST = 12'h000;
    localparam logic [31:0] NCOPM_ACC_RST = 32'h0000_0000;
    localparam logic [9:0] NCOPM_MIDSCALE = 10'h200;
    localparam logic [8:0] NCOPM_MAG_FULL = 9'h1ff;
    localparam real NCOPM_PI = 3.14159265358979;

    // Main pipeline state: all flops of the core except the sine stage register
    typedef struct packed {
        logic wr_n_q;                           // Previous level of the write strobe
        logic cap_valid_q;                      // Captured write waiting for commit
        logic [2:0] cap_addr_q;                 // Address caught at strobe rise
        logic [15:0] cap_data_q;                // Data caught at strobe rise
        logic [31:0] freq0_q;                   // Frequency word 0
        logic [31:0] freq1_q;                   // Frequency word 1
        logic [3:0][11:0] phase_q;              // Phase offsets 0..3
        logic fsel_q;                           // Sampled frequency choice
        logic [1:0] psel_q;                     // Sampled phase choice {hi, lo}
        logic [31:0] acc_q;                     // Phase accumulator
        logic [11:0] offset_q;                  // Selected phase offset
        logic [31:0] sum_q;                     // Offset-adjusted phase
        logic [11:0] lut_addr_q;                // Truncated sine address
        logic [9:0] amp_q;                      // Output amplitude code
    } ncopm_state_t;

    // Sine stage state
    typedef struct packed {
        logic [9:0] code_q;                     // Registered amplitude code
    } ncopm_sine_state_t;

endpackage

`default_nettype wire

// [ncopm_sine_table.sv]
// Sine table: 12-bit phase address to registered 10-bit amplitude code
`default_nettype none

module ncopm_sine_table
    import ncopm_pkg::*;
(
    input wire logic clock,                 // Master clock
    input wire logic srst,                  // Synchronous reset, active high
    input wire logic [11:0] phase_addr,     // Truncated phase
    output logic [9:0] amp_code             // Offset-binary code, midscale at phase 0
);

    // Quarter-wave magnitude sampled at the centre of each step, so mirroring is exact
    function automatic logic [8:0] quarter_mag(input int k);
        real ang;
        ang = NCOPM_PI * (real'(k) + 0.5) / (2.0 * real'(NCOPM_QTR_DEPTH));
        return 9'($rtoi(real'(NCOPM_MAG_FULL) * $sin(ang) + 0.5));
    endfunction

    logic [8:0] quarter_tbl [NCOPM_QTR_DEPTH];
    ncopm_sine_state_t st_q;
    ncopm_sine_state_t st_d;
    logic [9:0] idx;
    logic [8:0] mag;

    // ----------------------------------------------------------------
    // Table contents, fixed at elaboration
    // ----------------------------------------------------------------
    for (genvar gi = 0; gi < NCOPM_QTR_DEPTH; gi++)
    begin : g_tbl
        assign quarter_tbl[gi] = quarter_mag(gi);
    end

    // Quarter folding: second and fourth quarters read the table backwards
    always_comb
    begin
        idx = phase_addr[10] ? ~phase_addr[9:0] : phase_addr[9:0];
        mag = quarter_tbl[idx];
        st_d = st_q;
        if (phase_addr[11])
        begin
            st_d.code_q = NCOPM_MIDSCALE - {1'b0, mag};
        end
        else
        begin
            st_d.code_q = NCOPM_MIDSCALE + {1'b0, mag};
        end
        if (srst)
        begin
            st_d.code_q = NCOPM_MIDSCALE;
        end
    end

    // Single register stage
    always_ff @(posedge clock)
    begin
        st_q <= st_d;
    end

    assign amp_code = st_q.code_q;

endmodule

`default_nettype wire
